// File: rtl/cas_core.sv
// add/subtract execution core with low i/o bit operations, apb slave
//
// Overview of operation
// - add with carry flag, one clock, ZCNVH
// - immediate to register pair, two clocks, ZCNVS
// - some i/o flags clear on writing one
// - bit set/clear rewrites the whole register
// - bit set/clear only for i/o 0x00-0x1F
// - fuse off: shared slot is calibration register
`timescale 1ns/100ps
`include "cas_params.svh"
module cas_core
  import cas_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // pins
  input  wire logic [1:0]  event_in,
  input  wire logic        debug_enable_fuse,
  output logic [7:0]       osc_trim,
  output logic [7:0]       debug_data
);
  // ****************************************************************
  // state record
  // ****************************************************************
  typedef struct packed {
    cas_state_t       state;
    logic [31:0][7:0] gpr;
    logic [7:0]       flags;
    logic [31:0]      cmd;
    logic [4:0]       word_dst;
    logic             word_c;
    logic             word_zlo;
    logic [`CAS_EV_W-1:0] int_stat;
    logic [`CAS_EV_W-1:0] int_mask;
    logic [31:0]      rdata;
  } cas_core_state_t;

  cas_core_state_t r;
  cas_core_state_t next_r;

  cas_io_if io_bus ();

  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic       alu_cin;
  logic       alu_sub;
  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_h;
  logic       alu_v;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic in_win(input logic [11:0] a, input logic [11:0] base);
    return ((a & `CAS_WIN_MASK) == base) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    return a == `CAS_ADDR_CMD || a == `CAS_ADDR_FLAGS || a == `CAS_ADDR_STATUS ||
           a == `CAS_ADDR_INT_STAT || a == `CAS_ADDR_INT_MASK ||
           in_win(a, `CAS_GPR_BASE) || in_win(a, `CAS_IO_BASE);
  endfunction

  // ****************************************************************
  // flag arithmetic
  // ****************************************************************
  // c, z, n and v are shared by the byte ops and the upper half of the word op
  function automatic logic [7:0] arith_flags(input logic [7:0] f, input logic [7:0] res,
                                             input logic c, input logic v, input logic z);
    logic [7:0] o;
    o               = f;
    o[`CAS_FLAG_C]  = c;
    o[`CAS_FLAG_Z]  = z;
    o[`CAS_FLAG_N]  = res[7];
    o[`CAS_FLAG_V]  = v;
    return o;
  endfunction

  // ****************************************************************
  // command and bus decode
  // ****************************************************************
  logic        setup;
  logic        access;
  logic        wr_acc;
  logic [4:0]  win_idx;
  logic        cmd_go;
  cas_op_t     cmd_op;
  logic [2:0]  cmd_bit;
  logic [4:0]  cmd_dst;
  logic [5:0]  cmd_io;
  logic [4:0]  cmd_src;
  logic [7:0]  cmd_imm;

  always_comb begin
    setup   = psel && !penable;
    access  = psel && penable;
    wr_acc  = access && pwrite && is_mapped(paddr);
    win_idx = paddr[6:2];
    cmd_go  = wr_acc && paddr == `CAS_ADDR_CMD;
    cmd_op  = cas_op_t'(pwdata[`CAS_CMD_OP_LSB +: 3]);
    cmd_bit = pwdata[`CAS_CMD_BIT_LSB +: 3];
    cmd_dst = pwdata[`CAS_CMD_DST_LSB +: 5];
    cmd_io  = pwdata[`CAS_CMD_DST_LSB +: 6];
    cmd_src = pwdata[`CAS_CMD_SRC_LSB +: 5];
    cmd_imm = {2'b00, pwdata[`CAS_CMD_IMM_LSB +: 6]};
  end

  // ****************************************************************
  // apb answer and interrupt
  // ****************************************************************
  // every transfer is one setup and one access cycle
  // zero-wait slave; unmapped or misaligned addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && !is_mapped(paddr);
  assign prdata  = r.rdata;
  assign irq     = |(r.int_stat & r.int_mask);

  // ****************************************************************
  // shared adder
  // ****************************************************************
  always_comb begin
    alu_a   = r.gpr[cmd_dst];
    alu_b   = r.gpr[cmd_src];
    alu_cin = 1'b0;
    alu_sub = 1'b0;
    if (r.state == CAS_WORD_HI) begin
      // upper byte takes only the carry out of the lower byte
      alu_a   = r.gpr[r.word_dst];
      alu_b   = 8'h00;
      alu_cin = r.word_c;
    end else if (cmd_op == CAS_OP_WORD) begin
      alu_b   = cmd_imm;
    end else if (cmd_op == CAS_OP_ADC) begin
      alu_cin = r.flags[`CAS_FLAG_C];
    end else if (cmd_op == CAS_OP_SUB) begin
      alu_sub = 1'b1;
    end
  end

  cas_alu8 u_alu (
    .a     (alu_a),
    .b     (alu_b),
    .cin   (alu_cin),
    .sub   (alu_sub),
    .res   (alu_res),
    .carry (alu_c),
    .half  (alu_h),
    .ovf   (alu_v)
  );

  // ****************************************************************
  // low i/o space
  // ****************************************************************
  cas_io_space u_io (
    .pclk              (pclk),
    .presetn           (presetn),
    .bus               (io_bus.io),
    .event_in          (event_in),
    .debug_enable_fuse (debug_enable_fuse),
    .osc_trim          (osc_trim),
    .debug_data        (debug_data)
  );

  // ****************************************************************
  // i/o port steering
  // ****************************************************************
  logic io_bit_go;

  // limitation: bit ops reach only slots 0x00-0x1F; a wider address is refused
  always_comb begin
    io_bit_go = cmd_go && r.state == CAS_IDLE &&
                (cmd_op == CAS_OP_BSET || cmd_op == CAS_OP_BCLR) &&
                cmd_io <= `CAS_IO_LAST;
    io_bus.addr  = io_bit_go ? cmd_dst : win_idx;
    io_bus.wdata = pwdata[7:0];
    io_bus.wr    = wr_acc && in_win(paddr, `CAS_IO_BASE);
    if (io_bit_go) begin
      // whole register goes back, so a set w1c flag read here is cleared
      io_bus.wr    = 1'b1;
      io_bus.wdata = io_bus.rdata;
      io_bus.wdata[cmd_bit] = (cmd_op == CAS_OP_BSET);
    end
  end

  // ****************************************************************
  // register update
  // ****************************************************************
  always_comb begin
    logic [`CAS_EV_W-1:0] ev;
    logic                 n_flag;
    ev     = '0;
    n_flag = alu_res[7];
    next_r = r;

    // read data is captured in the setup phase, ready for the access edge
    if (setup && !pwrite) begin
      next_r.rdata = 32'h0000_0000;
      if (paddr == `CAS_ADDR_CMD) begin
        next_r.rdata = r.cmd;
      end else if (paddr == `CAS_ADDR_FLAGS) begin
        next_r.rdata = {24'h000000, r.flags};
      end else if (paddr == `CAS_ADDR_STATUS) begin
        next_r.rdata = {31'h0000_0000, r.state == CAS_WORD_HI};
      end else if (paddr == `CAS_ADDR_INT_STAT) begin
        next_r.rdata = {28'h000_0000, r.int_stat};
      end else if (paddr == `CAS_ADDR_INT_MASK) begin
        next_r.rdata = {28'h000_0000, r.int_mask};
      end else if (in_win(paddr, `CAS_GPR_BASE)) begin
        next_r.rdata = {24'h000000, r.gpr[win_idx]};
      end else if (in_win(paddr, `CAS_IO_BASE)) begin
        next_r.rdata = {24'h000000, io_bus.rdata};
      end
    end

    // clear only what the captured read reported; an event landing on the
    // setup edge is not in that word and must survive to the next read
    if (access && !pwrite && paddr == `CAS_ADDR_INT_STAT) begin
      next_r.int_stat = r.int_stat & ~r.rdata[`CAS_EV_W-1:0];
    end

    if (wr_acc) begin
      if (paddr == `CAS_ADDR_FLAGS) begin
        next_r.flags = pwdata[7:0];
      end else if (paddr == `CAS_ADDR_INT_MASK) begin
        next_r.int_mask = pwdata[`CAS_EV_W-1:0];
      end else if (in_win(paddr, `CAS_GPR_BASE)) begin
        next_r.gpr[win_idx] = pwdata[7:0];
      end else if (in_win(paddr, `CAS_IO_BASE) && io_bus.rsvd) begin
        ev[`CAS_EV_RSVD] = 1'b1;
      end
    end

    unique case (r.state)
      CAS_IDLE: begin
        if (cmd_go) begin
          next_r.cmd = pwdata;
          unique case (cmd_op)
            CAS_OP_ADD, CAS_OP_ADC, CAS_OP_SUB: begin
              next_r.gpr[cmd_dst]          = alu_res;
              next_r.flags = arith_flags(r.flags, alu_res, alu_c, alu_v, alu_res == 8'h00);
              next_r.flags[`CAS_FLAG_H]    = alu_h;
              ev[`CAS_EV_DONE]             = 1'b1;
            end
            CAS_OP_WORD: begin
              next_r.gpr[cmd_dst] = alu_res;
              // pair high byte wraps from register 31 to register 0
              next_r.word_dst     = 5'(cmd_dst + 5'd1);
              next_r.word_c       = alu_c;
              next_r.word_zlo     = alu_res == 8'h00;
              next_r.state        = CAS_WORD_HI;
            end
            CAS_OP_BSET, CAS_OP_BCLR: begin
              ev[`CAS_EV_DONE]  = io_bit_go;
              ev[`CAS_EV_RANGE] = !io_bit_go;
            end
            default: begin
              ev[`CAS_EV_REFUSED] = 1'b1;
            end
          endcase
        end
      end
      CAS_WORD_HI: begin
        // command writes during the second clock are dropped
        ev[`CAS_EV_REFUSED]       = cmd_go;
        next_r.gpr[r.word_dst]    = alu_res;
        next_r.flags              = arith_flags(r.flags, alu_res, alu_c, alu_v,
                                                r.word_zlo && alu_res == 8'h00);
        next_r.flags[`CAS_FLAG_S] = n_flag ^ alu_v;
        next_r.state              = CAS_IDLE;
        ev[`CAS_EV_DONE]          = 1'b1;
      end
    endcase

    // an event in the clearing read's cycle survives
    next_r.int_stat = next_r.int_stat | ev;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r       <= '0;
      r.state <= CAS_IDLE;
    end else begin
      r <= next_r;
    end
  end
endmodule

// File: inc/cas_params.svh
// constants of the add/subtract core and its low i/o space
`ifndef CAS_PARAMS_SVH
`define CAS_PARAMS_SVH

// ****************************************************************
// apb register map (byte addresses)
// ****************************************************************
`define CAS_ADDR_W        12
`define CAS_ADDR_CMD      12'h000
`define CAS_ADDR_FLAGS    12'h004
`define CAS_ADDR_STATUS   12'h008
`define CAS_ADDR_INT_STAT 12'h00C
`define CAS_ADDR_INT_MASK 12'h010
`define CAS_GPR_BASE      12'h100
`define CAS_IO_BASE       12'h200
`define CAS_WIN_MASK      12'hF80

// ****************************************************************
// command word fields
// ****************************************************************
`define CAS_CMD_OP_LSB    0
`define CAS_CMD_BIT_LSB   4
`define CAS_CMD_DST_LSB   8
`define CAS_CMD_SRC_LSB   16
`define CAS_CMD_IMM_LSB   24

// ****************************************************************
// flag bit positions
// ****************************************************************
`define CAS_FLAG_C        0
`define CAS_FLAG_Z        1
`define CAS_FLAG_N        2
`define CAS_FLAG_V        3
`define CAS_FLAG_S        4
`define CAS_FLAG_H        5

// ****************************************************************
// interrupt events
// ****************************************************************
`define CAS_EV_DONE       0
`define CAS_EV_RANGE      1
`define CAS_EV_RSVD       2
`define CAS_EV_REFUSED    3
`define CAS_EV_W          4

// ****************************************************************
// low i/o space
// ****************************************************************
`define CAS_IO_LAST       6'h1F
`define CAS_IO_SHARED     5'h04
`define CAS_IO_EVFLAG     5'h0E
`define CAS_IO_RSVD_LO    5'h1C
`define CAS_OSC_CAL_RST   8'h80

`endif

// File: inc/cas_pkg.sv
// types of the add/subtract core
package cas_pkg;

  typedef enum logic [2:0] {
    CAS_OP_ADD,
    CAS_OP_ADC,
    CAS_OP_SUB,
    CAS_OP_WORD,
    CAS_OP_BSET,
    CAS_OP_BCLR
  } cas_op_t;

  typedef enum logic {
    CAS_IDLE,
    CAS_WORD_HI
  } cas_state_t;

endpackage

// File: inc/cas_io_if.sv
// access port between the core and its low i/o space
`timescale 1ns/100ps
interface cas_io_if;
  logic       wr;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rsvd;

  modport core (output wr, output addr, output wdata, input rdata, input rsvd);
  modport io   (input wr, input addr, input wdata, output rdata, output rsvd);
endinterface

// File: rtl/cas_alu8.sv
// eight-bit adder/subtractor with status flags
`timescale 1ns/100ps
`include "cas_params.svh"
module cas_alu8
  import cas_pkg::*;
(
  // operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       sub,
  // result
  output logic [7:0]      res,
  output logic            carry,
  output logic            half,
  output logic            ovf
);
  logic [7:0] bx;
  logic       cx;
  logic [8:0] full;
  logic [4:0] low;

  // subtraction as a + ~b + ~borrow, carry flag reports borrow
  always_comb begin
    bx    = sub ? ~b : b;
    cx    = sub ? ~cin : cin;
    full  = {1'b0, a} + {1'b0, bx} + {8'h00, cx};
    low   = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
    res   = full[7:0];
    carry = full[8] ^ sub;
    half  = low[4] ^ sub;
    ovf   = (a[7] == bx[7]) && (full[7] != a[7]);
  end
endmodule

// File: rtl/cas_io_space.sv
// low i/o space: w1c event flags, reserved slots, shared calibration/debug slot
`timescale 1ns/100ps
`include "cas_params.svh"
module cas_io_space
  import cas_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // core access
  cas_io_if.io            bus,
  // pins
  input  wire logic [1:0] event_in,
  input  wire logic       debug_enable_fuse,
  output logic [7:0]      osc_trim,
  output logic [7:0]      debug_data
);
  typedef struct packed {
    logic [31:0][7:0] io;
    logic [7:0]       osc_cal;
    logic [7:0]       dbg;
    logic [1:0]       ev_s1;
    logic [1:0]       ev_s2;
    logic [1:0]       ev_old;
    logic             fuse_s1;
    logic             fuse_s2;
  } cas_io_state_t;

  cas_io_state_t r;
  cas_io_state_t next_r;

  function automatic logic is_rsvd(input logic [4:0] a);
    return a >= `CAS_IO_RSVD_LO;
  endfunction

  // ****************************************************************
  // read side
  // ****************************************************************
  always_comb begin
    bus.rsvd = is_rsvd(bus.addr);
    if (bus.rsvd) begin
      bus.rdata = 8'h00;
    end else if (bus.addr == `CAS_IO_SHARED) begin
      bus.rdata = r.fuse_s2 ? r.dbg : r.osc_cal;
    end else begin
      bus.rdata = r.io[bus.addr];
    end
  end

  // ****************************************************************
  // update
  // ****************************************************************
  always_comb begin
    logic [1:0] rise;
    rise          = '0;
    next_r        = r;
    next_r.ev_s1  = event_in;
    next_r.ev_s2  = r.ev_s1;
    next_r.ev_old = r.ev_s2;
    next_r.fuse_s1 = debug_enable_fuse;
    next_r.fuse_s2 = r.fuse_s1;
    rise          = r.ev_s2 & ~r.ev_old;
    // writes to reserved slots are dropped
    if (bus.wr && !is_rsvd(bus.addr)) begin
      if (bus.addr == `CAS_IO_SHARED) begin
        if (r.fuse_s2) begin
          next_r.dbg = bus.wdata;
        end else begin
          next_r.osc_cal = bus.wdata;
        end
      end else if (bus.addr == `CAS_IO_EVFLAG) begin
        next_r.io[`CAS_IO_EVFLAG][1:0] = r.io[`CAS_IO_EVFLAG][1:0] & ~bus.wdata[1:0];
        next_r.io[`CAS_IO_EVFLAG][7:2] = bus.wdata[7:2];
      end else begin
        next_r.io[bus.addr] = bus.wdata;
      end
    end
    // a new event beats a clear in the same cycle
    next_r.io[`CAS_IO_EVFLAG][1:0] = next_r.io[`CAS_IO_EVFLAG][1:0] | rise;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.osc_cal <= `CAS_OSC_CAL_RST;
    end else begin
      r <= next_r;
    end
  end

  assign osc_trim   = r.osc_cal;
  assign debug_data = r.dbg;
endmodule

// File: tb/cas_core_monitor.sv
// assertion checker for the add/subtract core ports
`timescale 1ns/100ps
module cas_core_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        debug_enable_fuse,
  input wire logic [7:0]  osc_trim,
  input wire logic [7:0]  debug_data
);
  logic       acc;
  logic       unmapped;
  logic       fuse_q;
  logic [1:0] fuse_age;
  assign acc = psel && penable;
  assign unmapped = (paddr[1:0] != 2'h0) || (paddr > 12'h010 && paddr < 12'h100)
                    || (paddr >= 12'h180 && paddr < 12'h200) || (paddr >= 12'h280);
  // fuse is synchronised inside, so trust it only once steady for three edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_q   <= 1'b0;
      fuse_age <= 2'h0;
    end else begin
      fuse_q   <= debug_enable_fuse;
      fuse_age <= (debug_enable_fuse != fuse_q) ? 2'h0 : fuse_age + {1'b0, fuse_age != 2'h3};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence seq_shared_write;
    acc && pwrite && paddr == 12'h210;
  endsequence
  chk_ready_zero_wait: assert property (acc |-> pready)
    else $error("access phase without ready");
  chk_err_decode: assert property (acc |-> pslverr == unmapped)
    else $error("slave error does not match address decode");
  chk_err_idle: assert property (!acc |-> !pslverr)
    else $error("slave error outside access phase");
  chk_err_read_zero: assert property (acc && !pwrite && unmapped |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  chk_byte_wide_read: assert property (acc && !pwrite && paddr >= 12'h100 |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_rsvd_read_zero: assert property (
    acc && !pwrite && paddr[11:4] == 8'h27 && paddr[1:0] == 2'h0 |-> prdata == 32'h0)
    else $error("reserved slot read not zero");
  chk_cal_write: assert property (
    seq_shared_write ##0 (fuse_age == 2'h3 && !fuse_q)
      |=> osc_trim == $past(pwdata[7:0]) && $stable(debug_data))
    else $error("shared slot write missed calibration");
  chk_dbg_write: assert property (
    seq_shared_write ##0 (fuse_age == 2'h3 && fuse_q)
      |=> debug_data == $past(pwdata[7:0]) && $stable(osc_trim))
    else $error("shared slot write missed debug register");
  chk_pins_hold: assert property (
    !(acc && pwrite && (paddr == 12'h210 || paddr == 12'h000))
      |=> $stable(osc_trim) && $stable(debug_data))
    else $error("pin registers changed without a write");
endmodule

bind cas_core cas_core_monitor u_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .debug_enable_fuse(debug_enable_fuse),
  .osc_trim(osc_trim), .debug_data(debug_data));

// File: tb/tb_cas_core.sv
// self-checking apb bench for the add/subtract core
`timescale 1ns/100ps
module tb_cas_core
  import cas_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, fuse, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [1:0]  event_in;
  logic [7:0]  osc_trim, debug_data;
  int          num_errors = 0;
  int          num_checks = 0;

  cas_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .event_in(event_in), .debug_enable_fuse(fuse),
    .osc_trim(osc_trim), .debug_data(debug_data));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen 0x%08h expected 0x%08h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait limit here: only the watchdog may end a stalled transfer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdv, exp);
  endtask

  // read-clears the events, then checks only the bit of interest
  task automatic ev_chk(input logic [31:0] bitv);
    apb(1'b0, 12'h00C, 32'h0);
    check(rdv & bitv, bitv);
  endtask

  function automatic logic [31:0] cmd(input cas_op_t op, input logic [2:0] bt,
                                      input logic [5:0] dst, input logic [5:0] imm);
    // source register 3 sits in bits 20:16
    return {2'h0, imm, 10'h00C, dst, 1'h0, bt, 1'h0, op};
  endfunction

  task automatic run8(input cas_op_t op, input logic [7:0] a, input logic [7:0] b,
                      input logic [7:0] fin);
    logic [8:0] s;
    logic       ci;
    logic       h;
    logic       v;
    ci = (op == CAS_OP_ADC) && fin[0];
    s = (op == CAS_OP_SUB) ? {1'h0, a} - {1'h0, b} : {1'h0, a} + {1'h0, b} + {8'h0, ci};
    h = (op == CAS_OP_SUB) ? a[3:0] < b[3:0] : {1'h0, a[3:0]} + {1'h0, b[3:0]} + ci > 5'h0F;
    v = ((a[7] ^ b[7]) == (op == CAS_OP_SUB)) && (s[7] != a[7]);
    apb(1'b1, 12'h108, {24'h0, a});
    apb(1'b1, 12'h10C, {24'h0, b});
    apb(1'b1, 12'h004, {24'h0, fin});
    apb(1'b1, 12'h000, cmd(op, 3'h0, 6'h02, 6'h00));
    rd_chk(12'h108, {24'h0, s[7:0]});
    rd_chk(12'h004, {26'h0, h, fin[4], v, s[7], s[7:0] == 8'h00, s[8]});
  endtask

  task automatic run16(input logic [4:0] d, input logic [15:0] w, input logic [5:0] k,
                       input logic [7:0] fin);
    logic [16:0] s;
    logic        v;
    s = {1'h0, w} + {11'h0, k};
    v = !w[15] && s[15];
    apb(1'b1, {5'h02, d, 2'h0}, {24'h0, w[7:0]});
    apb(1'b1, {5'h02, d + 5'h01, 2'h0}, {24'h0, w[15:8]});
    apb(1'b1, 12'h004, {24'h0, fin});
    apb(1'b1, 12'h000, cmd(CAS_OP_WORD, 3'h0, {1'h0, d}, k));
    rd_chk({5'h02, d, 2'h0}, {24'h0, s[7:0]});
    rd_chk({5'h02, d + 5'h01, 2'h0}, {24'h0, s[15:8]});
    rd_chk(12'h004, {26'h0, fin[5], s[15] ^ v, v, s[15], s[15:0] == 16'h0, s[16]});
  endtask

  // event pins pass a two-stage synchroniser
  task automatic pulse(input int n);
    event_in[n] <= 1'b1;
    repeat (3) @(posedge pclk);
    event_in[n] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    complete_run();
  end

  initial begin
    {presetn, psel, penable, pwrite, fuse} = 5'h0;
    {paddr, pwdata, event_in} = 46'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    check({osc_trim, debug_data}, 32'h8000);
    apb(1'b1, 12'h010, 32'h0);
    run8(CAS_OP_ADD, 8'h7F, 8'h01, 8'h10);
    @(negedge pclk);
    check(irq, 1'b0);
    apb(1'b1, 12'h010, 32'hF);
    @(negedge pclk);
    check(irq, 1'b1);
    rd_chk(12'h010, 32'hF);
    ev_chk(32'h1);
    @(negedge pclk);
    check(irq, 1'b0);
    run8(CAS_OP_ADD, 8'hFF, 8'h01, 8'h00);
    run8(CAS_OP_ADD, 8'h0F, 8'h01, 8'h01);
    run8(CAS_OP_ADC, 8'hFF, 8'h00, 8'h01);
    run8(CAS_OP_ADC, 8'h3C, 8'h43, 8'h30);
    run8(CAS_OP_SUB, 8'h00, 8'h01, 8'h00);
    run8(CAS_OP_SUB, 8'h80, 8'h01, 8'h11);
    run8(CAS_OP_SUB, 8'h55, 8'h55, 8'h00);
    run16(5'h1E, 16'hFFFF, 6'h01, 8'h20);
    run16(5'h1F, 16'h7FFF, 6'h01, 8'h00);
    run16(5'h04, 16'h1234, 6'h3F, 8'h1F);
    rd_chk(12'h000, cmd(CAS_OP_WORD, 3'h0, 6'h04, 6'h3F));
    rd_chk(12'h008, 32'h0);
    apb(1'b1, 12'h238, 32'h54);
    pulse(0);
    rd_chk(12'h238, 32'h55);
    apb(1'b1, 12'h000, cmd(CAS_OP_BSET, 3'h7, 6'h0E, 6'h00));
    rd_chk(12'h238, 32'hD4);
    pulse(1);
    apb(1'b1, 12'h000, cmd(CAS_OP_BCLR, 3'h6, 6'h0E, 6'h00));
    rd_chk(12'h238, 32'h94);
    pulse(0);
    apb(1'b1, 12'h238, 32'h95);
    rd_chk(12'h238, 32'h94);
    apb(1'b1, 12'h000, cmd(CAS_OP_BSET, 3'h3, 6'h00, 6'h00));
    rd_chk(12'h200, 32'h08);
    apb(1'b0, 12'h00C, 32'h0);
    apb(1'b1, 12'h000, cmd(CAS_OP_BSET, 3'h2, 6'h20, 6'h00));
    ev_chk(32'h2);
    apb(1'b1, 12'h270, 32'hFF);
    rd_chk(12'h270, 32'h0);
    ev_chk(32'h4);
    apb(1'b1, 12'h000, cmd(cas_op_t'(3'h6), 3'h0, 6'h00, 6'h00));
    ev_chk(32'h8);
    apb(1'b0, 12'h020, 32'h0);
    check(rdv, 32'h0);
    check(errv, 1'b1);
    apb(1'b1, 12'h102, 32'h1);
    check(errv, 1'b1);
    apb(1'b1, 12'h210, 32'h3C);
    rd_chk(12'h210, 32'h3C);
    fuse <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, 12'h210, 32'hA5);
    @(negedge pclk);
    check({osc_trim, debug_data}, 32'h3CA5);
    fuse <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(12'h210, 32'h3C);
    complete_run();
  end
endmodule
